//--- rtl/clk_ctl_defs.vh
// register map, field positions and reset values of the clock control slice
`ifndef CLK_CTL_DEFS_VH
`define CLK_CTL_DEFS_VH

// register offsets (byte addresses)
`define GATES_OFFSET 8'h1c
`define BACKUP_OFFSET 8'h20

// slow bus clock gate register
`define GATES_RESET 32'h00000000
`define GATES_WRITABLE 32'h70e2c913
`define BIT_CONSUMER_CTL 30
`define BIT_DAC_IFACE 29
`define BIT_POWER_IFACE 28
`define BIT_USB_DEVICE 23
`define BIT_SECOND_I2C 22
`define BIT_FIRST_I2C 21
`define BIT_SECOND_SERIAL 17
`define BIT_THIRD_SPI 15
`define BIT_SECOND_SPI 14
`define BIT_WINDOW_WATCHDOG 11
`define BIT_TIMER_THIRTEEN 8
`define BIT_TIMER_FIVE 4
`define BIT_TIMER_TWO 1
`define BIT_TIMER_ONE 0

// backup domain clock control register
`define BACKUP_RESET 32'h00000018
`define BIT_BACKUP_RESET_REQ 16
`define BIT_RTC_KERNEL_GATE 15
`define RTC_SRC_HI 9
`define RTC_SRC_LO 8
`define DRIVE_HI 4
`define DRIVE_LO 3
`define BIT_CRYSTAL_BYPASS 2
`define BIT_CRYSTAL_STABLE 1
`define BIT_CRYSTAL_ON 0
`define DRIVE_RESET 2'h3
`define RTC_SRC_RESET 2'h0

// rtc source encodings
`define RTC_SRC_NONE 2'h0
`define RTC_SRC_SLOW_CRYSTAL 2'h1
`define RTC_SRC_INTERNAL_40K 2'h2
`define RTC_SRC_FAST_DIV32 2'h3

`endif

//--- rtl/clock_gate_cell.v
// glitch-free clock gate for one peripheral clock
`timescale 1ns/1ps

module clock_gate_cell (
	input wire clk,
	input wire rst,
	input wire clk_en,
	input wire enable,
	output wire gated_clk
);

	reg enable_low;

	// ===========================================================
	// enable capture while the clock is low
	// the enable only changes while clk is low, so the and gate never chops a high phase
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			enable_low <= 1'b0;
		end else if (clk_en) begin
			enable_low <= enable;
		end
	end

	assign gated_clk = clk & enable_low;

endmodule // clock_gate_cell

//--- rtl/apb1_gate_backup_clock_ctl.v
// slow bus peripheral clock gates and backup domain clock control
//
// Notes on behaviour
// - bit 30 gates the consumer control interface clock; software sets and clears it.
// - bit 29 gates the dac interface clock, bit 28 the power interface clock.
// - bits 23, 22, 21 gate usb device, second i2c and first i2c clocks.
// - bit 17 gates second serial, bits 15 and 14 third and second spi.
// - bit 11 gates the window watchdog clock.
// - bit 8 gates timer thirteen, bit 4 gates timer five.
// - bit 1 gates timer two, bit 0 gates timer one.
// - gate register at 0x1c resets to zero; reserved bits stay zero.
// - backup register resets to 0x18 only by backup reset, not system reset.
// - backup register takes byte, half word and word writes per byte lane.
// - crystal on, bypass, rtc source and rtc gate writable only while unlocked.
// - bit 16 high holds the whole backup domain in reset.
// - bit 15 gates the rtc kernel clock.
// - rtc source: none, slow crystal, internal 40k, fast crystal over 32.
// - drive field bits 4:3, lowest 00 to highest 11, resets to 11.
// - bit 2 puts the slow crystal into bypass, taking an external clock.
// - bit 0 enables the slow crystal; read-only bit 1 shows it stable.
`timescale 1ns/1ps
`include "clk_ctl_defs.vh"

module apb1_gate_backup_clock_ctl (
	input wire core_clk,
	input wire rst,
	input wire bkp_rst,
	input wire clk_en,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [3:0] reg_byte_en,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// power unit and crystal pins
	input wire backup_write_unlock,
	input wire slow_crystal_ready_pin,
	// gated peripheral clocks
	output wire consumer_ctl_clk,
	output wire dac_iface_clk,
	output wire power_iface_clk,
	output wire usb_device_clk,
	output wire second_i2c_clk,
	output wire first_i2c_clk,
	output wire second_serial_clk,
	output wire third_spi_clk,
	output wire second_spi_clk,
	output wire window_watchdog_clk,
	output wire timer_thirteen_clk,
	output wire timer_five_clk,
	output wire timer_two_clk,
	output wire timer_one_clk,
	// backup domain controls
	output reg backup_domain_reset_req,
	output reg rtc_kernel_clk_gate,
	output reg [1:0] rtc_source_select,
	output reg [1:0] slow_crystal_drive,
	output reg slow_crystal_bypass,
	output reg slow_crystal_on,
	output reg slow_crystal_stable
);

	// ===========================================================
	// byte lane decode
	// lanes apply to both registers, which keeps one write path for each
	reg [31:0] gates;
	wire [31:0] lane_mask;
	wire gates_hit;
	wire backup_hit;
	wire gates_wr;
	wire backup_wr;
	wire [31:0] next_gates;

	assign lane_mask = {{8{reg_byte_en[3]}}, {8{reg_byte_en[2]}}, {8{reg_byte_en[1]}}, {8{reg_byte_en[0]}}};
	assign gates_hit = (reg_addr == `GATES_OFFSET);
	assign backup_hit = (reg_addr == `BACKUP_OFFSET);
	assign gates_wr = reg_wr & gates_hit;
	assign backup_wr = reg_wr & backup_hit;

	// ===========================================================
	// slow bus clock gate register
	// only documented gate bits can be written; reserved bits hold their reset zero
	// every clock therefore starts stopped until software opens its gate
	assign next_gates = (gates & ~(lane_mask & `GATES_WRITABLE)) | (reg_wdata & lane_mask & `GATES_WRITABLE);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gates <= `GATES_RESET;
		end else if (clk_en && gates_wr) begin
			gates <= next_gates;
		end
	end

	// ===========================================================
	// gated peripheral clocks
	// one gate cell per clock; the cell moves its enable on the falling edge
	// the gated clocks are the only outputs not taken from a flop: a flop cannot carry a clock
	// clk_en low freezes the captured enables, so a running clock keeps running while frozen
	clock_gate_cell consumer_ctl_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_CONSUMER_CTL]),
		.gated_clk(consumer_ctl_clk)
	);

	clock_gate_cell dac_iface_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_DAC_IFACE]),
		.gated_clk(dac_iface_clk)
	);

	clock_gate_cell power_iface_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_POWER_IFACE]),
		.gated_clk(power_iface_clk)
	);

	clock_gate_cell usb_device_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_USB_DEVICE]),
		.gated_clk(usb_device_clk)
	);

	clock_gate_cell second_i2c_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_SECOND_I2C]),
		.gated_clk(second_i2c_clk)
	);

	clock_gate_cell first_i2c_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_FIRST_I2C]),
		.gated_clk(first_i2c_clk)
	);

	clock_gate_cell second_serial_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_SECOND_SERIAL]),
		.gated_clk(second_serial_clk)
	);

	clock_gate_cell third_spi_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_THIRD_SPI]),
		.gated_clk(third_spi_clk)
	);

	clock_gate_cell second_spi_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_SECOND_SPI]),
		.gated_clk(second_spi_clk)
	);

	clock_gate_cell window_watchdog_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_WINDOW_WATCHDOG]),
		.gated_clk(window_watchdog_clk)
	);

	clock_gate_cell timer_thirteen_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_TIMER_THIRTEEN]),
		.gated_clk(timer_thirteen_clk)
	);

	clock_gate_cell timer_five_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_TIMER_FIVE]),
		.gated_clk(timer_five_clk)
	);

	clock_gate_cell timer_two_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_TIMER_TWO]),
		.gated_clk(timer_two_clk)
	);

	clock_gate_cell timer_one_gate (
		.clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.enable(gates[`BIT_TIMER_ONE]),
		.gated_clk(timer_one_clk)
	);

	// ===========================================================
	// backup domain write qualification
	wire lane0_wr;
	wire lane1_wr;
	wire lane2_wr;
	wire protected0_wr;
	wire protected1_wr;

	assign lane0_wr = backup_wr & reg_byte_en[0];
	assign lane1_wr = backup_wr & reg_byte_en[1];
	assign lane2_wr = backup_wr & reg_byte_en[2];
	// power unit unlock guards the oscillator and rtc bits, not the drive or reset request
	// so a locked domain can still be reset and retuned from software
	assign protected0_wr = lane0_wr & backup_write_unlock;
	assign protected1_wr = lane1_wr & backup_write_unlock;

	// ===========================================================
	// backup domain reset request
	// of the two resets only the backup reset pin clears it; software holds and releases it by writing bit 16
	always @(posedge core_clk or posedge bkp_rst) begin
		if (bkp_rst) begin
			backup_domain_reset_req <= 1'b0;
		end else if (clk_en && lane2_wr) begin
			backup_domain_reset_req <= reg_wdata[`BIT_BACKUP_RESET_REQ];
		end
	end

	// ===========================================================
	// backup domain clock control fields
	// system reset does not reach these flops, only the backup reset does
	// a write that lands while the hold is set is dropped, not queued: clear bit 16 first
	always @(posedge core_clk or posedge bkp_rst) begin
		if (bkp_rst) begin
			rtc_kernel_clk_gate <= 1'b0;
			rtc_source_select <= `RTC_SRC_RESET;
			slow_crystal_drive <= `DRIVE_RESET;
			slow_crystal_bypass <= 1'b0;
			slow_crystal_on <= 1'b0;
		end else if (clk_en) begin
			if (backup_domain_reset_req) begin
				// held in reset: fields forced to reset values, writes lost
				rtc_kernel_clk_gate <= 1'b0;
				rtc_source_select <= `RTC_SRC_RESET;
				slow_crystal_drive <= `DRIVE_RESET;
				slow_crystal_bypass <= 1'b0;
				slow_crystal_on <= 1'b0;
			end else begin
				if (protected0_wr) begin
					slow_crystal_on <= reg_wdata[`BIT_CRYSTAL_ON];
					slow_crystal_bypass <= reg_wdata[`BIT_CRYSTAL_BYPASS];
				end
				if (lane0_wr) begin
					slow_crystal_drive <= reg_wdata[`DRIVE_HI:`DRIVE_LO];
				end
				if (protected1_wr) begin
					rtc_source_select <= reg_wdata[`RTC_SRC_HI:`RTC_SRC_LO];
					rtc_kernel_clk_gate <= reg_wdata[`BIT_RTC_KERNEL_GATE];
				end
			end
		end
	end

	// ===========================================================
	// slow crystal ready synchroniser
	// the ready pin is asynchronous; stage one feeds stage two only
	// a one-cycle glitch on the pin never reaches the flag, stages two and three must agree
	reg ready_s1;
	reg ready_s2;
	reg ready_s3;
	reg ready_filt;

	always @(posedge core_clk or posedge bkp_rst) begin
		if (bkp_rst) begin
			ready_s1 <= 1'b0;
			ready_s2 <= 1'b0;
			ready_s3 <= 1'b0;
			ready_filt <= 1'b0;
		end else if (clk_en) begin
			ready_s1 <= slow_crystal_ready_pin;
			ready_s2 <= ready_s1;
			ready_s3 <= ready_s2;
			if (ready_s2 == ready_s3) begin
				ready_filt <= ready_s3;
			end
		end
	end

	// ===========================================================
	// stable flag
	// hardware owns it; no write path exists, so software writes are dropped
	// limitation: no settle counter here, the oscillator's ready pin is trusted as is
	// the hold request clears the flag too, as the whole domain counts as in reset
	always @(posedge core_clk or posedge bkp_rst) begin
		if (bkp_rst) begin
			slow_crystal_stable <= 1'b0;
		end else if (clk_en) begin
			slow_crystal_stable <= slow_crystal_on & ready_filt & ~backup_domain_reset_req;
		end
	end

	// ===========================================================
	// read data, valid in the cycle after the read strobe
	// reserved bits of both registers read as zero whatever software wrote
	// the read register holds between reads, so a late sample still sees the last answer
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h00000000;
		if (gates_hit) begin
			next_rdata = gates;
		end else if (backup_hit) begin
			next_rdata[`BIT_BACKUP_RESET_REQ] = backup_domain_reset_req;
			next_rdata[`BIT_RTC_KERNEL_GATE] = rtc_kernel_clk_gate;
			next_rdata[`RTC_SRC_HI:`RTC_SRC_LO] = rtc_source_select;
			next_rdata[`DRIVE_HI:`DRIVE_LO] = slow_crystal_drive;
			next_rdata[`BIT_CRYSTAL_BYPASS] = slow_crystal_bypass;
			next_rdata[`BIT_CRYSTAL_STABLE] = slow_crystal_stable;
			next_rdata[`BIT_CRYSTAL_ON] = slow_crystal_on;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (clk_en && reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // apb1_gate_backup_clock_ctl

//--- testbench/clk_ctl_monitor.sv
// assertions on the register port and backup domain controls
`timescale 1ns/1ps
`include "clk_ctl_defs.vh"

module clk_ctl_monitor (
	input wire core_clk,
	input wire rst,
	input wire bkp_rst,
	input wire clk_en,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [3:0] reg_byte_en,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire backup_write_unlock,
	input wire backup_domain_reset_req,
	input wire rtc_kernel_clk_gate,
	input wire [1:0] slow_crystal_drive,
	input wire slow_crystal_on,
	input wire slow_crystal_stable
);
// ==========
// properties
default clocking @(posedge core_clk); endclocking
default disable iff (rst || bkp_rst);
wire bk_wr = clk_en && reg_wr && reg_addr == `BACKUP_OFFSET;
wire held = backup_domain_reset_req;
a_unmapped_reads: assert property (clk_en && reg_rd && reg_addr != `GATES_OFFSET && reg_addr != `BACKUP_OFFSET
	|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
a_gate_reserved: assert property (clk_en && reg_rd && reg_addr == `GATES_OFFSET
	|=> (reg_rdata & ~`GATES_WRITABLE) == 32'h0) else $error("reserved gate bits read set");
a_locked_on: assert property (bk_wr && reg_byte_en[0] && !backup_write_unlock
	|=> $stable(slow_crystal_on) || held) else $error("locked write changed crystal enable");
a_unlocked_on: assert property (bk_wr && reg_byte_en[0] && backup_write_unlock && !held
	|=> slow_crystal_on == $past(reg_wdata[0]) || held) else $error("crystal enable not written");
a_drive_write: assert property (bk_wr && reg_byte_en[0] && !held
	|=> slow_crystal_drive == $past(reg_wdata[4:3]) || held) else $error("drive field not written");
a_reset_req_bit: assert property (bk_wr && reg_byte_en[2]
	|=> held == $past(reg_wdata[16])) else $error("reset request bit not written");
a_hold_in_reset: assert property (clk_en && held && !reg_wr
	|=> !slow_crystal_on && !rtc_kernel_clk_gate && slow_crystal_drive == `DRIVE_RESET) else $error("fields not held");
a_stable_off: assert property (clk_en && !slow_crystal_on
	|=> !slow_crystal_stable) else $error("stable flag set with crystal off");
endmodule // clk_ctl_monitor

bind apb1_gate_backup_clock_ctl clk_ctl_monitor mon (.core_clk, .rst, .bkp_rst, .clk_en, .reg_addr, .reg_wdata,
	.reg_byte_en, .reg_wr, .reg_rd, .reg_rdata, .backup_write_unlock, .backup_domain_reset_req, .rtc_kernel_clk_gate,
	.slow_crystal_drive, .slow_crystal_on, .slow_crystal_stable);

//--- testbench/tb_top.sv
// self-checking bench for the clock control slice
`timescale 1ns/1ps
`include "clk_ctl_defs.vh"

module tb_top;
logic core_clk = 1'b0, rst = 1'b1, bkp_rst = 1'b1, clk_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
logic backup_write_unlock = 1'b0, slow_crystal_ready_pin = 1'b0;
logic [7:0] reg_addr = 8'h00;
logic [31:0] reg_wdata = 32'h0;
logic [3:0] reg_byte_en = 4'h0;
wire [31:0] reg_rdata;
wire [13:0] clks;
wire [1:0] src;
wire req_o, gate_o, byp_o, on_o, stb_o;
wire [1:0] drv_o;
// backup outputs laid out as the register reads, so one compare covers every pin
wire [31:0] bk_view = {15'h0, req_o, gate_o, 5'h0, src, 3'h0, drv_o, byp_o, stb_o, on_o};
int errors = 0, tests_run = 0, cyc = 0;
int bits[14] = '{30, 29, 28, 23, 22, 21, 17, 15, 14, 11, 8, 4, 1, 0};
logic [31:0] q[$];
logic pend = 1'b0;
logic [31:0] v;

apb1_gate_backup_clock_ctl uut (.core_clk, .rst, .bkp_rst, .clk_en, .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr,
	.reg_rd, .reg_rdata, .backup_write_unlock, .slow_crystal_ready_pin, .consumer_ctl_clk(clks[13]),
	.dac_iface_clk(clks[12]), .power_iface_clk(clks[11]), .usb_device_clk(clks[10]), .second_i2c_clk(clks[9]),
	.first_i2c_clk(clks[8]), .second_serial_clk(clks[7]), .third_spi_clk(clks[6]), .second_spi_clk(clks[5]),
	.window_watchdog_clk(clks[4]), .timer_thirteen_clk(clks[3]), .timer_five_clk(clks[2]), .timer_two_clk(clks[1]),
	.timer_one_clk(clks[0]), .backup_domain_reset_req(req_o), .rtc_kernel_clk_gate(gate_o),
	.rtc_source_select(src), .slow_crystal_drive(drv_o), .slow_crystal_bypass(byp_o), .slow_crystal_on(on_o),
	.slow_crystal_stable(stb_o));

always #20 core_clk = ~core_clk;

// ==========
// tasks
task chk(input logic [31:0] seen, input logic [31:0] exp);
	tests_run++;
	if (seen !== exp) begin
		errors++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask

task acc(input logic r, input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
	reg_rd <= r;
	reg_wr <= w;
	reg_addr <= a;
	reg_wdata <= d;
	reg_byte_en <= be;
	@(posedge core_clk);
endtask

task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
	acc(1'b0, 1'b1, a, d, be);
endtask

task rd(input logic [7:0] a, input logic [31:0] e);
	q.push_back(e);
	acc(1'b1, 1'b0, a, 32'h0, 4'h0);
endtask

task idle(input int n);
	repeat (n) acc(1'b0, 1'b0, 8'h00, 32'h0, 4'h0);
endtask

// gated clocks must pulse in the high phase and stay low in the low phase
task ck(input logic [31:0] g);
	logic [13:0] e;
	for (int i = 0; i < 14; i++) e[13-i] = g[bits[i]];
	idle(2);
	#10;
	chk({18'h0, clks}, {18'h0, e});
	#20;
	chk({18'h0, clks}, 32'h0);
	@(posedge core_clk);
endtask

task done(input string s);
	$display("test %s done", s);
endtask

task final_report;
	$display("comparisons %0d mismatches %0d", tests_run, errors);
	if (errors == 0 && tests_run > 0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask

// ==========
// read checker and timeout
always @(posedge core_clk) begin
	if (pend) chk(reg_rdata, q.pop_front());
	pend = reg_rd && clk_en;
	cyc++;
	if (cyc == 3000) begin
		errors++;
		final_report;
	end
end

// ==========
// stimulus
initial begin
	void'($urandom(32'he596));
	repeat (6) @(posedge core_clk);
	rst <= 1'b0;
	bkp_rst <= 1'b0;
	clk_en <= 1'b1;
	@(posedge core_clk);
	rd(`GATES_OFFSET, `GATES_RESET);
	rd(`BACKUP_OFFSET, `BACKUP_RESET);
	ck(32'h0);
	done("reset");
	foreach (bits[i]) begin
		wr(`GATES_OFFSET, 32'h1 << bits[i], 4'hf);
		rd(`GATES_OFFSET, 32'h1 << bits[i]);
		ck(32'h1 << bits[i]);
	end
	repeat (8) begin
		v = $urandom & `GATES_WRITABLE;
		wr(`GATES_OFFSET, ($urandom & ~`GATES_WRITABLE) | v, 4'hf);
		rd(`GATES_OFFSET, v);
		ck(v);
	end
	wr(8'h24, 32'hffffffff, 4'hf);
	rd(8'h24, 32'h0);
	clk_en <= 1'b0;
	wr(`GATES_OFFSET, 32'h0, 4'hf);
	clk_en <= 1'b1;
	rd(`GATES_OFFSET, v);
	done("gates");
	backup_write_unlock <= 1'b1;
	wr(`BACKUP_OFFSET, 32'hffffffff, 4'h1);
	rd(`BACKUP_OFFSET, 32'h1d);
	chk(bk_view, 32'h1d);
	for (int s = 0; s < 4; s++) begin
		wr(`BACKUP_OFFSET, {22'h0, s[1:0], 8'h0} | 32'h8000, 4'h2);
		rd(`BACKUP_OFFSET, 32'h801d | (s << 8));
		chk({30'h0, src}, s);
	end
	backup_write_unlock <= 1'b0;
	wr(`BACKUP_OFFSET, 32'h0, 4'hf);
	rd(`BACKUP_OFFSET, 32'h8305);
	chk(bk_view, 32'h8305);
	done("backup lanes");
	slow_crystal_ready_pin <= 1'b1;
	idle(8);
	rd(`BACKUP_OFFSET, 32'h8307);
	chk(bk_view, 32'h8307);
	backup_write_unlock <= 1'b1;
	wr(`BACKUP_OFFSET, 32'h2, 4'h1);
	idle(1);
	rd(`BACKUP_OFFSET, 32'h8300);
	chk(bk_view, 32'h8300);
	done("crystal");
	wr(`BACKUP_OFFSET, 32'h10000, 4'h4);
	wr(`BACKUP_OFFSET, 32'h8101, 4'h3);
	rd(`BACKUP_OFFSET, 32'h10018);
	chk(bk_view, 32'h10018);
	wr(`BACKUP_OFFSET, 32'h0, 4'h4);
	wr(`BACKUP_OFFSET, 32'h8204, 4'h3);
	rd(`BACKUP_OFFSET, 32'h8204);
	idle(2);
	rst <= 1'b1;
	idle(2);
	rst <= 1'b0;
	idle(1);
	rd(`BACKUP_OFFSET, 32'h8204);
	rd(`GATES_OFFSET, 32'h0);
	idle(2);
	bkp_rst <= 1'b1;
	idle(2);
	bkp_rst <= 1'b0;
	idle(1);
	rd(`BACKUP_OFFSET, `BACKUP_RESET);
	chk(bk_view, `BACKUP_RESET);
	idle(2);
	done("resets");
	final_report;
end
endmodule // tb_top
